// ### logic/ppc_defines.svh
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PPC_ADDR_FN_HIGH 8'h1c
`define PPC_ADDR_FN_LOW 8'h1d
`define PPC_ADDR_PU_EN 8'h1e
`define PPC_ADDR_OD_SEL 8'hf5

// ************************************************************
// Reset values
// ************************************************************
`define PPC_RST_FN_HIGH 8'h00
`define PPC_RST_FN_LOW 8'h00
`define PPC_RST_PU_EN 8'h00
`define PPC_RST_OD_SEL 8'h00
`define PPC_RDATA_UNMAPPED 8'h00

// ************************************************************
// Field layout
// ************************************************************
`define PPC_FIELD_W 2
`define PPC_PINS_PER_REG 4

// ************************************************************
// LCD segment numbering of port B pins 0 to 7
// ************************************************************
`define PPC_LCD_SEGMENT_OUT_FIRST 36
`define PPC_LCD_SEGMENT_OUT_LAST 43

`endif

// ### logic/ppc_pkg.sv
`include "ppc_defines.svh"

package ppc_pkg;

   // Function of one port B pin
   typedef enum logic [1:0] {
      ppc_fn_input = 2'h0,
      ppc_fn_emi = 2'h1,
      ppc_fn_lcd = 2'h2,
      ppc_fn_output = 2'h3
   } ppc_fn_t;

   typedef logic [7:0] ppc_byte_t;

   // Picks the 2-bit field of a pin out of the high and low registers
   function automatic ppc_fn_t ppc_fn_of(ppc_byte_t hi, ppc_byte_t lo, logic [2:0] pin);
      ppc_byte_t r;
      logic [1:0] slot;
      r = pin[2] ? hi : lo;
      slot = pin[1:0];
      return ppc_fn_t'(r[{slot, 1'b0} +: `PPC_FIELD_W]);
   endfunction

endpackage

// ### logic/ppc_cfg_if.sv
`timescale 1ns/1ps

// Carries port B configuration to the pin decoder and its results back
interface ppc_cfg_if;
   logic [7:0] fn_high;
   logic [7:0] fn_low;
   logic [7:0] pu_en;
   logic [7:0] gpio_out;
   logic [7:0] emi_out;
   logic [7:0] emi_oe;
   logic [7:0] lcd_seg;
   logic [7:0] pad_o_d;
   logic [7:0] pad_oe_n_d;
   logic [7:0] pullup_d;

   modport cfg (
      output fn_high, fn_low, pu_en, gpio_out, emi_out, emi_oe, lcd_seg,
      input pad_o_d, pad_oe_n_d, pullup_d
   );
   modport mux (
      input fn_high, fn_low, pu_en, gpio_out, emi_out, emi_oe, lcd_seg,
      output pad_o_d, pad_oe_n_d, pullup_d
   );
endinterface

// ### logic/ppc_port_b_mux.sv
`timescale 1ns/1ps

module ppc_port_b_mux (
   // Configuration and results
   ppc_cfg_if.mux bus
);

   // ************************************************************
   // Per-pin function decode
   // ************************************************************

   // Steers each pin by its field and gates its pull-up
   always_comb begin
      ppc_pkg::ppc_fn_t fn;
      fn = ppc_pkg::ppc_fn_input;
      bus.pad_o_d = 8'h00;
      bus.pad_oe_n_d = 8'hff;
      bus.pullup_d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         fn = ppc_pkg::ppc_fn_of(bus.fn_high, bus.fn_low, 3'(i));
         case (fn)
            ppc_pkg::ppc_fn_input: begin
               bus.pad_oe_n_d[i] = 1'b1;
               bus.pullup_d[i] = bus.pu_en[i];
            end
            ppc_pkg::ppc_fn_emi: begin
               bus.pad_o_d[i] = bus.emi_out[i];
               bus.pad_oe_n_d[i] = ~bus.emi_oe[i];
            end
            ppc_pkg::ppc_fn_lcd: begin
               bus.pad_o_d[i] = bus.lcd_seg[i];
               bus.pad_oe_n_d[i] = 1'b0;
            end
            default: begin
               bus.pad_o_d[i] = bus.gpio_out[i];
               bus.pad_oe_n_d[i] = 1'b0;
            end
         endcase
         // Pull-up stays off in every mode but input
         if (fn != ppc_pkg::ppc_fn_input) begin
            bus.pullup_d[i] = 1'b0;
         end
      end
   end

endmodule

// ### logic/ppc_top.sv
`timescale 1ns/1ps
`include "ppc_defines.svh"

module ppc_top (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_page8,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Port A pins
   input wire logic [7:0] port_a_out_en,
   input wire logic [7:0] port_a_out_data,
   output logic [7:0] port_a_pad_o,
   output logic [7:0] port_a_pad_oe_n,
   // Port B sources
   input wire logic [7:0] port_b_gpio_out,
   input wire logic [7:0] emi_out_data,
   input wire logic [7:0] emi_out_en,
   input wire logic [7:0] lcd_seg_drive,
   // Port B pins
   input wire logic [7:0] port_b_pad_i,
   output logic [7:0] port_b_pad_o,
   output logic [7:0] port_b_pad_oe_n,
   output logic [7:0] port_b_pullup_on,
   output logic [7:0] port_b_in_q
);

   ppc_cfg_if cfg_bus ();

   // ************************************************************
   // Register file
   // ************************************************************

   logic [7:0] fn_high_q, fn_high_d;
   logic [7:0] fn_low_q, fn_low_d;
   logic [7:0] pu_en_q, pu_en_d;
   logic [7:0] od_sel_q, od_sel_d;
   logic [7:0] rdata_q, rdata_d;
   logic hit_high, hit_low, hit_pu, hit_od;

   // Address decode; port B sits in page 8, port A in the other space
   always_comb begin
      hit_high = 1'b0;
      hit_low = 1'b0;
      hit_pu = 1'b0;
      hit_od = 1'b0;
      if (reg_page8 && reg_addr == `PPC_ADDR_FN_HIGH) begin
         hit_high = 1'b1;
      end else if (reg_page8 && reg_addr == `PPC_ADDR_FN_LOW) begin
         hit_low = 1'b1;
      end else if (reg_page8 && reg_addr == `PPC_ADDR_PU_EN) begin
         hit_pu = 1'b1;
      end else if (!reg_page8 && reg_addr == `PPC_ADDR_OD_SEL) begin
         hit_od = 1'b1;
      end
   end

   // Next register values and read data
   always_comb begin
      fn_high_d = fn_high_q;
      fn_low_d = fn_low_q;
      pu_en_d = pu_en_q;
      od_sel_d = od_sel_q;
      rdata_d = rdata_q;
      if (reg_wr) begin
         if (hit_high) fn_high_d = reg_wdata;
         if (hit_low) fn_low_d = reg_wdata;
         if (hit_pu) pu_en_d = reg_wdata;
         if (hit_od) od_sel_d = reg_wdata;
      end
      if (reg_rd) begin
         if (hit_high) begin
            rdata_d = fn_high_q;
         end else if (hit_low) begin
            rdata_d = fn_low_q;
         end else if (hit_pu) begin
            rdata_d = pu_en_q;
         end else if (hit_od) begin
            rdata_d = od_sel_q;
         end else begin
            rdata_d = `PPC_RDATA_UNMAPPED;
         end
      end
   end

   // Registers, frozen while ce is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fn_high_q <= `PPC_RST_FN_HIGH;
         fn_low_q <= `PPC_RST_FN_LOW;
         pu_en_q <= `PPC_RST_PU_EN;
         od_sel_q <= `PPC_RST_OD_SEL;
         rdata_q <= `PPC_RDATA_UNMAPPED;
      end else if (ce) begin
         fn_high_q <= fn_high_d;
         fn_low_q <= fn_low_d;
         pu_en_q <= pu_en_d;
         od_sel_q <= od_sel_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ************************************************************
   // Port B decode
   // ************************************************************

   // Hand configuration and sources to the decoder
   assign cfg_bus.fn_high = fn_high_q;
   assign cfg_bus.fn_low = fn_low_q;
   assign cfg_bus.pu_en = pu_en_q;
   assign cfg_bus.gpio_out = port_b_gpio_out;
   assign cfg_bus.emi_out = emi_out_data;
   assign cfg_bus.emi_oe = emi_out_en;
   assign cfg_bus.lcd_seg = lcd_seg_drive;

   ppc_port_b_mux u_port_b_mux (
      .bus(cfg_bus.mux)
   );

   // ************************************************************
   // Pin registers
   // ************************************************************

   logic [7:0] a_pad_o_q, a_pad_o_d;
   logic [7:0] a_oe_n_q, a_oe_n_d;
   logic [7:0] b_pad_o_q, b_oe_n_q, b_pu_q, b_in_q;

   // Port A drive: open-drain only pulls low, never drives high
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!port_a_out_en[i]) begin
            a_pad_o_d[i] = 1'b0;
            a_oe_n_d[i] = 1'b1;
         end else if (od_sel_q[i]) begin
            a_pad_o_d[i] = 1'b0;
            a_oe_n_d[i] = port_a_out_data[i];
         end else begin
            a_pad_o_d[i] = port_a_out_data[i];
            a_oe_n_d[i] = 1'b0;
         end
      end
   end

   // All pin outputs come from flip-flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         a_pad_o_q <= 8'h00;
         a_oe_n_q <= 8'hff;
         b_pad_o_q <= 8'h00;
         b_oe_n_q <= 8'hff;
         b_pu_q <= 8'h00;
         b_in_q <= 8'h00;
      end else if (ce) begin
         a_pad_o_q <= a_pad_o_d;
         a_oe_n_q <= a_oe_n_d;
         b_pad_o_q <= cfg_bus.pad_o_d;
         b_oe_n_q <= cfg_bus.pad_oe_n_d;
         b_pu_q <= cfg_bus.pullup_d;
         b_in_q <= port_b_pad_i;
      end
   end

   assign port_a_pad_o = a_pad_o_q;
   assign port_a_pad_oe_n = a_oe_n_q;
   assign port_b_pad_o = b_pad_o_q;
   assign port_b_pad_oe_n = b_oe_n_q;
   assign port_b_pullup_on = b_pu_q;
   assign port_b_in_q = b_in_q;

   // ************************************************************
   // Assertions
   // ************************************************************

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Write of output mode into pin 7 field of the high register
   sequence s_high_pin7_out;
      ce && reg_wr && reg_page8 && reg_addr == `PPC_ADDR_FN_HIGH && reg_wdata[7:6] == 2'h3;
   endsequence

   // Write of input mode into pin 0 field of the low register
   sequence s_low_pin0_in;
      ce && reg_wr && reg_page8 && reg_addr == `PPC_ADDR_FN_LOW && reg_wdata[1:0] == 2'h0;
   endsequence

   a_high_field_map: assert property (s_high_pin7_out ##1 ce |=> !port_b_pad_oe_n[7])
      else $error("Pin 7 not driven after output mode write");

   a_low_field_map: assert property (s_low_pin0_in ##1 ce |=> port_b_pad_oe_n[0])
      else $error("Pin 0 still driven after input mode write");

   a_emi_route: assert property (ce &&
      ppc_pkg::ppc_fn_of(fn_high_q, fn_low_q, 3'h1) == ppc_pkg::ppc_fn_emi
      |=> port_b_pad_o[1] == $past(emi_out_data[1]) && port_b_pad_oe_n[1] == !$past(emi_out_en[1]))
      else $error("Memory interface not routed to pin 1");

   a_lcd_route: assert property (ce &&
      ppc_pkg::ppc_fn_of(fn_high_q, fn_low_q, 3'h3) == ppc_pkg::ppc_fn_lcd
      |=> port_b_pad_o[3] == $past(lcd_seg_drive[3]) && !port_b_pad_oe_n[3])
      else $error("LCD segment not routed to pin 3");

   a_pullup_enable: assert property (ce &&
      ppc_pkg::ppc_fn_of(fn_high_q, fn_low_q, 3'h5) == ppc_pkg::ppc_fn_input
      |=> port_b_pullup_on[5] == $past(pu_en_q[5]))
      else $error("Pin 5 pull-up does not follow its enable");

   // Mode seen at the edge decides the pull-up registered at that edge
   a_pullup_forced: assert property (ce &&
      ppc_pkg::ppc_fn_of(fn_high_q, fn_low_q, 3'h6) != ppc_pkg::ppc_fn_input
      |=> !port_b_pullup_on[6])
      else $error("Pin 6 pull-up on outside input mode");

   a_open_drain_high: assert property (ce && od_sel_q[2] && port_a_out_en[2] && port_a_out_data[2]
      |=> port_a_pad_oe_n[2] && !port_a_pad_o[2])
      else $error("Open-drain pin 2 drove a high level");

   a_push_pull_high: assert property (ce && !od_sel_q[2] && port_a_out_en[2] && port_a_out_data[2]
      |=> !port_a_pad_oe_n[2] && port_a_pad_o[2])
      else $error("Push-pull pin 2 did not drive high");

   a_idle_no_drive: assert property ((ce && !port_a_out_en[4])[*2] |=> port_a_pad_oe_n[4] && !port_a_pad_o[4])
      else $error("Disabled pin 4 driven");

endmodule

// ### verification/ppc_pins_model.sv
`timescale 1ns/1ps

// Board side of port B: resolves each pad from the drive, the pull-up or nothing
module ppc_pins_model (
   // Clock
   input wire logic clk,
   // Pad controls from the block
   input wire logic [7:0] pad_o,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] pullup_on,
   // Resolved pad levels
   output logic [7:0] pad_i
);
   logic [7:0] float_q = 8'h55;

   // A floating pin shows a pattern that changes every cycle, never a held value
   always @(posedge clk) begin
      float_q <= ~float_q;
   end

   // Driver wins, then the pull-up, else the pin floats
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_i[i] = !pad_oe_n[i] ? pad_o[i] : (pullup_on[i] ? 1'b1 : float_q[i]);
      end
   end
endmodule

// ### verification/port_pin_configuration_test.sv
`timescale 1ns/1ps
`include "ppc_defines.svh"

module port_pin_configuration_test;
   logic clk, rst_n, ce, reg_page8, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, a_en, a_data, a_o, a_oe_n;
   logic [7:0] gpio, emi_d, emi_en, lcd, b_i, b_o, b_oe_n, b_pu, b_in_q;
   logic [7:0] e_o, e_oe, e_pu, m;
   int miscompares = 0;
   int checks_done = 0;

   ppc_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_page8(reg_page8),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .port_a_out_en(a_en), .port_a_out_data(a_data), .port_a_pad_o(a_o), .port_a_pad_oe_n(a_oe_n),
      .port_b_gpio_out(gpio), .emi_out_data(emi_d), .emi_out_en(emi_en), .lcd_seg_drive(lcd),
      .port_b_pad_i(b_i), .port_b_pad_o(b_o), .port_b_pad_oe_n(b_oe_n), .port_b_pullup_on(b_pu),
      .port_b_in_q(b_in_q));

   ppc_pins_model pins (.clk(clk), .pad_o(b_o), .pad_oe_n(b_oe_n), .pullup_on(b_pu), .pad_i(b_i));

   // ************************************************************
   // Clock and tasks
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Compares one byte
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write strobe, direct register access
   task automatic reg_write(input logic pg, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_page8 = pg;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   // One-cycle read strobe; data is there one edge later
   task automatic reg_read(input logic pg, input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_page8 = pg;
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("reg_rdata", exp, reg_rdata);
   endtask

   // Ends the run with the verdict
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Expected port B pins from the two function bytes, walked pin by pin
   task automatic expect_b(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] pu);
      logic [15:0] all;
      logic [1:0] f;
      all = {hi, lo};
      for (int i = 0; i < 8; i++) begin
         f = (i < 4) ? lo[2 * i +: 2] : hi[2 * (i - 4) +: 2];
         m[i] = (f != 2'h0);
         e_o[i] = (f == 2'h1) ? emi_d[i] : (f == 2'h2) ? lcd[i] : gpio[i];
         e_oe[i] = (f == 2'h0) ? 1'b1 : (f == 2'h1) ? !emi_en[i] : 1'b0;
         e_pu[i] = (f == 2'h0) & pu[i];
      end
      if (all === 16'h0) m = 8'h0;
   endtask

   // Programs port B and checks the pads one edge after the write lands
   task automatic try_b(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] pu);
      reg_write(1'b1, `PPC_ADDR_FN_HIGH, hi);
      reg_write(1'b1, `PPC_ADDR_FN_LOW, lo);
      reg_write(1'b1, `PPC_ADDR_PU_EN, pu);
      @(negedge clk);
      expect_b(hi, lo, pu);
      chk("port_b_pad_o", e_o & m, b_o & m);
      chk("port_b_pad_oe_n", e_oe, b_oe_n);
      chk("port_b_pullup_on", e_pu, b_pu);
      @(negedge clk);
      chk("port_b_in_q", (~e_oe & e_o) | (e_oe & e_pu) | (e_oe & ~e_pu & b_in_q), b_in_q);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      rst_n = 1'b0; ce = 1'b1; reg_page8 = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
      reg_addr = 8'h00; reg_wdata = 8'h00; a_en = 8'h00; a_data = 8'h00;
      gpio = 8'h5a; emi_d = 8'h3c; emi_en = 8'h0f; lcd = 8'h96;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      // Reset values and an unmapped place
      chk("port_a_pad_oe_n", 8'hff, a_oe_n);
      reg_read(1'b1, `PPC_ADDR_FN_HIGH, `PPC_RST_FN_HIGH);
      reg_read(1'b1, `PPC_ADDR_FN_LOW, `PPC_RST_FN_LOW);
      reg_read(1'b1, `PPC_ADDR_PU_EN, `PPC_RST_PU_EN);
      reg_read(1'b0, `PPC_ADDR_OD_SEL, `PPC_RST_OD_SEL);
      reg_write(1'b1, 8'h1f, 8'hff);
      reg_read(1'b1, 8'h1f, `PPC_RDATA_UNMAPPED);
      $display("test reset done");
      // Port A: push-pull low nibble, open-drain high nibble, then inputs
      reg_write(1'b0, `PPC_ADDR_OD_SEL, 8'hf0);
      reg_read(1'b0, `PPC_ADDR_OD_SEL, 8'hf0);
      a_en = 8'hff;
      a_data = 8'ha5;
      @(negedge clk);
      chk("port_a_pad_o", 8'h05, a_o);
      chk("port_a_pad_oe_n", 8'ha0, a_oe_n);
      a_en = 8'h00;
      @(negedge clk);
      chk("port_a_pad_oe_n", 8'hff, a_oe_n);
      $display("test port a done");
      // Clock enable low: the write is ignored and read data holds
      ce = 1'b0;
      reg_write(1'b0, `PPC_ADDR_OD_SEL, 8'h0f);
      reg_read(1'b0, 8'h1f, 8'hf0);
      ce = 1'b1;
      reg_read(1'b0, `PPC_ADDR_OD_SEL, 8'hf0);
      $display("test clock enable done");
      // Port B: every mode on every pin, then a mixed field pattern, then all inputs with other pull-ups
      for (int k = 0; k < 4; k++) begin
         try_b({4{k[1:0]}}, {4{k[1:0]}}, 8'hff);
      end
      try_b(8'he4, 8'h1b, 8'h3c);
      try_b(8'h00, 8'h00, 8'ha5);
      reg_read(1'b1, `PPC_ADDR_FN_LOW, 8'h00);
      $display("test port b done");
      // Second reset in mid-run: pads released, registers back to reset values
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("port_b_pad_oe_n", 8'hff, b_oe_n);
      chk("port_b_pullup_on", `PPC_RST_PU_EN, b_pu);
      reg_read(1'b0, `PPC_ADDR_OD_SEL, `PPC_RST_OD_SEL);
      $display("test second reset done");
      complete_run();
   end

   // Watchdog well beyond the fewer than a hundred cycles the tests need
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end
endmodule
